// *** hw/ccd_single_channel_readout.sv ***
// single-channel sensor readout: apb registers, serial loader, sampler, output
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module ccd_single_channel_readout
   import ccd_readout_pkg::*;
#(
   parameter int RESULT_WIDTH = 16
)(
   input  wire logic                                  pclk,
   input  wire logic                                  presetn,
   input  wire logic [ccd_readout_pkg::APB_ADDR_W-1:0] paddr,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [ccd_readout_pkg::APB_DATA_W-1:0] pwdata,
   output logic      [ccd_readout_pkg::APB_DATA_W-1:0] prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   input  wire logic                                  conversion_output_clock,
   input  wire logic                                  reset_sample_strobe,
   input  wire logic                                  video_sample_strobe,
   input  wire logic                                  clamp_enable_in,
   input  wire logic                                  serial_config_data,
   input  wire logic                                  serial_shift_clock,
   input  wire logic                                  register_write_strobe,
   input  wire logic                                  output_enable_n,
   input  wire logic [ccd_readout_pkg::RESULT_W-1:0]   red_input,
   input  wire logic [ccd_readout_pkg::RESULT_W-1:0]   green_input,
   input  wire logic [ccd_readout_pkg::RESULT_W-1:0]   blue_input,
   output logic      [ccd_readout_pkg::RESULT_W-1:0]   result_bus,
   output logic                                       result_bus_oe,
   output logic      [ccd_readout_pkg::BYTE_W-1:0]     byte_bus,
   output logic                                       byte_bus_oe,
   output logic                                       clamp_active
);
   import ccd_readout_pkg::*;

   generate
      if (RESULT_WIDTH != RESULT_W) begin : width_check
         $error("only a 16-bit result word is supported");
      end
   endgenerate

   localparam int PIN_W  = 8;
   localparam int P_CONV = 0;
   localparam int P_RST  = 1;
   localparam int P_VID  = 2;
   localparam int P_CLP  = 3;
   localparam int P_SD   = 4;
   localparam int P_SCLK = 5;
   localparam int P_WRT  = 6;
   localparam int P_OEN  = 7;
   localparam int DATA_W = 3 * RESULT_W;
   // sync chain starts at the pins' idle levels, so release brings no false edge
   localparam logic [PIN_W-1:0] PIN_IDLE = 8'hC0;

   logic [PIN_W-1:0]    pin_raw;
   logic [PIN_W-1:0]    pin_meta;
   logic [PIN_W-1:0]    pin_sync;
   logic [PIN_W-1:0]    pin_prev;
   logic [DATA_W-1:0]   data_meta;
   logic [DATA_W-1:0]   data_sync;
   logic [PIN_W-1:0]    pin_rise;
   logic [PIN_W-1:0]    pin_fall;
   logic [7:0]          config_reg;
   logic [OFFSET_W-1:0] offset_reg [3];
   logic [RESULT_W-1:0] result_reg;
   logic [SERIAL_FRAME_W-1:0] shift_reg;
   logic                timing_err;
   logic                pending;
   logic                drive_en;
   logic                single_mode;
   logic                format_demux;
   channel_t            chan;
   out_state_t          out_state;
   logic                apb_wr;
   logic                apb_rd_setup;
   logic                ser_commit;
   logic [SERIAL_ADDR_W-1:0] ser_addr;
   logic [OFFSET_W-1:0] ser_data;
   logic [RESULT_W-1:0] next_sample;

   sampler_if smp ();

   correlated_double_sampler u_sampler (
      .pclk    (pclk),
      .presetn (presetn),
      .smp     (smp.sampler)
   );

   function automatic logic reg_known(input logic [APB_ADDR_W-1:0] addr);
      reg_known = (addr == CONFIG_OFFSET) || (addr == OFFSET_R_OFFSET) ||
                  (addr == OFFSET_G_OFFSET) || (addr == OFFSET_B_OFFSET) ||
                  (addr == RESULT_OFFSET) || (addr == STATUS_OFFSET);
   endfunction

   // pin synchronisers
   assign pin_raw = {output_enable_n, register_write_strobe, serial_shift_clock,
                     serial_config_data, clamp_enable_in, video_sample_strobe,
                     reset_sample_strobe, conversion_output_clock};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_meta  <= PIN_IDLE;
         pin_sync  <= PIN_IDLE;
         pin_prev  <= PIN_IDLE;
         data_meta <= 48'h0000_0000_0000;
         data_sync <= 48'h0000_0000_0000;
      end else begin
         pin_meta  <= pin_raw;
         pin_sync  <= pin_meta;
         pin_prev  <= pin_sync;
         data_meta <= {blue_input, green_input, red_input};
         data_sync <= data_meta;
      end
   end

   assign pin_rise = pin_sync & ~pin_prev;
   assign pin_fall = ~pin_sync & pin_prev;

   // apb decode
   assign pready       = 1'b1;
   assign apb_wr       = psel && penable && pwrite && reg_known(paddr);
   assign apb_rd_setup = psel && !penable && !pwrite;
   assign pslverr      = psel && penable && !reg_known(paddr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd_setup) begin
         case (paddr)
            CONFIG_OFFSET:   prdata <= {24'h000000, config_reg};
            OFFSET_R_OFFSET: prdata <= {22'h0, offset_reg[0]};
            OFFSET_G_OFFSET: prdata <= {22'h0, offset_reg[1]};
            OFFSET_B_OFFSET: prdata <= {22'h0, offset_reg[2]};
            RESULT_OFFSET:   prdata <= {16'h0000, result_reg};
            STATUS_OFFSET:   prdata <= {29'h0, pending, clamp_active, timing_err};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= 13'h0;
      end else if (pin_rise[P_SCLK] && !pin_sync[P_WRT]) begin
         shift_reg <= {shift_reg[SERIAL_FRAME_W-2:0], pin_sync[P_SD]};
      end
   end

   assign ser_commit = pin_rise[P_WRT];
   assign ser_addr   = shift_reg[SERIAL_FRAME_W-1:OFFSET_W];
   assign ser_data   = shift_reg[OFFSET_W-1:0];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_reg <= CONFIG_RESET;
      end else if (apb_wr && paddr == CONFIG_OFFSET) begin
         config_reg <= pwdata[7:0];
      end else if (ser_commit && ser_addr == SER_CONFIG) begin
         config_reg <= ser_data[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         offset_reg[0] <= OFFSET_RESET;
         offset_reg[1] <= OFFSET_RESET;
         offset_reg[2] <= OFFSET_RESET;
      end else if (apb_wr && paddr == OFFSET_R_OFFSET) begin
         offset_reg[0] <= pwdata[OFFSET_W-1:0];
      end else if (apb_wr && paddr == OFFSET_G_OFFSET) begin
         offset_reg[1] <= pwdata[OFFSET_W-1:0];
      end else if (apb_wr && paddr == OFFSET_B_OFFSET) begin
         offset_reg[2] <= pwdata[OFFSET_W-1:0];
      end else if (ser_commit && ser_addr == SER_OFFSET_R) begin
         offset_reg[0] <= ser_data;
      end else if (ser_commit && ser_addr == SER_OFFSET_G) begin
         offset_reg[1] <= ser_data;
      end else if (ser_commit && ser_addr == SER_OFFSET_B) begin
         offset_reg[2] <= ser_data;
      end
   end

   assign single_mode  = config_reg[SINGLE_CHANNEL_SELECT_BIT];
   assign format_demux = config_reg[OUTPUT_FORMAT_BIT];
   assign chan = decode_channel(config_reg[CHANNEL_SELECT_LOW_BIT],
                                config_reg[CHANNEL_SELECT_HIGH_BIT]);

   always_comb begin
      case (chan)
         CH_GREEN: next_sample = data_sync[2*RESULT_W-1:RESULT_W];
         CH_BLUE:  next_sample = data_sync[3*RESULT_W-1:2*RESULT_W];
         default:  next_sample = data_sync[RESULT_W-1:0];
      endcase
   end

   assign smp.sample_in  = next_sample;
   assign smp.offset     = offset_reg[chan];
   assign smp.reset_take = single_mode && pin_fall[P_RST];
   assign smp.video_take = single_mode && pin_fall[P_VID];

   // strobe phase check, set beats clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timing_err <= 1'b0;
      end else if ((pin_rise[P_RST] && !pin_sync[P_CONV]) ||
                   (single_mode && pin_fall[P_VID] && pin_sync[P_CONV])) begin
         timing_err <= 1'b1;
      end else if (apb_wr && paddr == STATUS_OFFSET && pwdata[STATUS_TIMING_BIT]) begin
         timing_err <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clamp_active <= 1'b0;
      end else begin
         clamp_active <= pin_sync[P_CLP] && pin_sync[P_RST];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending    <= 1'b0;
         result_reg <= RESULT_RESET;
      end else if (smp.held_valid) begin
         pending    <= 1'b1;
      end else if (pending && pin_rise[P_CONV]) begin
         pending    <= 1'b0;
         result_reg <= smp.held;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_state  <= OUT_IDLE;
         result_bus <= RESULT_RESET;
         byte_bus   <= 8'h00;
      end else begin
         case (out_state)
            OUT_IDLE, OUT_LOWER: begin
               if (pending && !smp.held_valid && pin_rise[P_CONV]) begin
                  byte_bus <= smp.held[RESULT_W-1:BYTE_W];
                  if (format_demux) begin
                     result_bus <= {smp.held[RESULT_W-1:BYTE_W], 8'h00};
                     out_state  <= OUT_UPPER;
                  end else begin
                     result_bus <= smp.held;
                     out_state  <= OUT_IDLE;
                  end
               end
            end
            OUT_UPPER: begin
               if (pin_fall[P_CONV]) begin
                  byte_bus   <= result_reg[BYTE_W-1:0];
                  result_bus <= {result_reg[BYTE_W-1:0], 8'h00};
                  out_state  <= OUT_LOWER;
               end
            end
            default: begin
               out_state <= OUT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drive_en <= 1'b0;
      end else begin
         drive_en <= !pin_sync[P_OEN];
      end
   end

   assign result_bus_oe = drive_en;
   assign byte_bus_oe   = drive_en;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   single_gate_a: assert property (!single_mode |=> !smp.held_valid)
      else $error("conversion started outside single-channel mode");
   blue_select_a: assert property (config_reg[5:4] == 2'b01 |-> smp.sample_in == data_sync[47:32])
      else $error("blue input not routed");
   mux_fixed_a: assert property (!apb_wr && !ser_commit |=> $stable(chan))
      else $error("channel changed without a config write");
   launch_word_a: assert property (pending && pin_rise[P_CONV] && !smp.held_valid |=> result_reg == $past(smp.held) && !pending)
      else $error("result not launched on conversion clock rise");
   normal_out_a: assert property (pending && pin_rise[P_CONV] && !smp.held_valid && !format_demux |=> result_bus == result_reg)
      else $error("normal mode word wrong");
   demux_upper_a: assert property (pending && pin_rise[P_CONV] && !smp.held_valid && format_demux |=> byte_bus == result_reg[15:8] && out_state == OUT_UPPER)
      else $error("upper byte not presented");
   demux_lower_a: assert property (out_state == OUT_UPPER && pin_fall[P_CONV] |=> byte_bus == result_reg[7:0])
      else $error("lower byte not presented");
   byte_lines_a: assert property (format_demux && out_state != OUT_IDLE |-> byte_bus == result_bus[15:8])
      else $error("byte lines disagree with word lines");
   clamp_gate_a: assert property (clamp_active |-> $past(pin_sync[P_CLP]) && $past(pin_sync[P_RST]))
      else $error("clamp active without enable and reset strobe");
   drive_gate_a: assert property (pin_sync[P_OEN] ##1 pin_sync[P_OEN] |=> !result_bus_oe)
      else $error("result lines driven while enable high");
   serial_load_a: assert property (ser_commit && ser_addr == SER_CONFIG && !apb_wr |=> config_reg == $past(shift_reg[7:0]))
      else $error("serial config write lost");

   normal_cov:  cover property (pending && pin_rise[P_CONV] && !format_demux);
   demux_cov:   cover property (out_state == OUT_UPPER ##[1:20] out_state == OUT_LOWER);
   timing_cov:  cover property ($rose(timing_err));
   serial_cov:  cover property (ser_commit && ser_addr == SER_CONFIG);
endmodule

// *** hw/ccd_readout_pkg.sv ***
// constants, types and the channel decoder shared by the readout design
package ccd_readout_pkg;
   localparam int          APB_ADDR_W     = 8;
   localparam int          APB_DATA_W     = 32;
   localparam int          RESULT_W       = 16;
   localparam int          BYTE_W         = 8;
   localparam int          OFFSET_W       = 10;
   localparam int          SAT_W          = 18;
   localparam int          SERIAL_ADDR_W  = 3;
   localparam int          SERIAL_FRAME_W = SERIAL_ADDR_W + OFFSET_W;

   localparam logic [7:0]  CONFIG_OFFSET  = 8'h00;
   localparam logic [7:0]  OFFSET_R_OFFSET = 8'h04;
   localparam logic [7:0]  OFFSET_G_OFFSET = 8'h08;
   localparam logic [7:0]  OFFSET_B_OFFSET = 8'h0C;
   localparam logic [7:0]  RESULT_OFFSET  = 8'h10;
   localparam logic [7:0]  STATUS_OFFSET  = 8'h14;

   localparam int          SINGLE_CHANNEL_SELECT_BIT = 3;
   localparam int          CHANNEL_SELECT_LOW_BIT    = 4;
   localparam int          CHANNEL_SELECT_HIGH_BIT   = 5;
   localparam int          OUTPUT_FORMAT_BIT         = 7;
   localparam logic [7:0]  CONFIG_RESET   = 8'h00;
   localparam logic [OFFSET_W-1:0] OFFSET_RESET = 10'h000;
   localparam logic [RESULT_W-1:0] RESULT_RESET = 16'h0000;

   localparam int          STATUS_TIMING_BIT = 0;
   localparam int          STATUS_CLAMP_BIT  = 1;
   localparam int          STATUS_PEND_BIT   = 2;

   localparam logic [SERIAL_ADDR_W-1:0] SER_CONFIG   = 3'h0;
   localparam logic [SERIAL_ADDR_W-1:0] SER_OFFSET_R = 3'h1;
   localparam logic [SERIAL_ADDR_W-1:0] SER_OFFSET_G = 3'h2;
   localparam logic [SERIAL_ADDR_W-1:0] SER_OFFSET_B = 3'h3;

   typedef enum logic [1:0] {CH_RED, CH_GREEN, CH_BLUE} channel_t;
   typedef enum logic [1:0] {OUT_IDLE, OUT_UPPER, OUT_LOWER} out_state_t;

   function automatic channel_t decode_channel(input logic low_bit, input logic high_bit);
      case ({high_bit, low_bit})
         2'b01:   decode_channel = CH_BLUE;
         2'b10:   decode_channel = CH_GREEN;
         default: decode_channel = CH_RED;
      endcase
   endfunction
endpackage

// *** hw/sampler_if.sv ***
// link between the readout control and the double sampler
`timescale 1ns/1ps
interface sampler_if;
   logic        reset_take;
   logic        video_take;
   logic [15:0] sample_in;
   logic [9:0]  offset;
   logic [15:0] held;
   logic        held_valid;
   modport ctrl    (output reset_take, video_take, sample_in, offset,
                    input  held, held_valid);
   modport sampler (input  reset_take, video_take, sample_in, offset,
                    output held, held_valid);
endinterface

// *** hw/correlated_double_sampler.sv ***
// reset/video level capture with offset and saturating difference
`timescale 1ns/1ps
module correlated_double_sampler
   import ccd_readout_pkg::*;
(
   input  wire logic    pclk,
   input  wire logic    presetn,
   sampler_if.sampler   smp
);
   logic [RESULT_W-1:0] reset_level;
   logic signed [SAT_W-1:0] diff;

   always_comb begin
      diff = $signed({2'b00, smp.sample_in}) - $signed({2'b00, reset_level})
             + $signed({{(SAT_W-OFFSET_W){smp.offset[OFFSET_W-1]}}, smp.offset});
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reset_level <= RESULT_RESET;
      end else if (smp.reset_take) begin
         reset_level <= smp.sample_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smp.held       <= RESULT_RESET;
         smp.held_valid <= 1'b0;
      end else begin
         smp.held_valid <= smp.video_take;
         if (smp.video_take) begin
            if (diff[SAT_W-1]) begin
               smp.held <= 16'h0000;
            end else if (diff[SAT_W-2]) begin
               smp.held <= 16'hFFFF;
            end else begin
               smp.held <= diff[RESULT_W-1:0];
            end
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   reset_capture_a: assert property (smp.reset_take |=> reset_level == $past(smp.sample_in))
      else $error("reset level not captured");
   video_hold_a: assert property (!smp.video_take |=> $stable(smp.held) && !smp.held_valid)
      else $error("held difference moved without a video sample");
endmodule

// *** dv/ccd_timing_model.sv ***
// timing generator and sensor levels on the far side of the readout
`timescale 1ns/1ps
module ccd_timing_model (
   input  wire logic        pclk,
   output logic             conversion_output_clock,
   output logic             reset_sample_strobe,
   output logic             video_sample_strobe,
   output logic [15:0]      red_input,
   output logic [15:0]      green_input,
   output logic [15:0]      blue_input
);
   initial begin
      conversion_output_clock = 1'b0;
      reset_sample_strobe = 1'b0;
      video_sample_strobe = 1'b0;
      red_input = 16'h0000;
      green_input = 16'h0000;
      blue_input = 16'h0000;
   end

   // one pixel; bad misplaces both strobes against the conversion clock
   // reset rise high
   task automatic sample(input logic [15:0] rl, vr, vg, vb, input logic bad);
      @(posedge pclk);
      conversion_output_clock <= ~bad;
      red_input <= rl;
      green_input <= rl;
      blue_input <= rl;
      repeat (4) @(posedge pclk);
      reset_sample_strobe <= 1'b1;
      repeat (4) @(posedge pclk);
      reset_sample_strobe <= 1'b0;
      repeat (6) @(posedge pclk);
      conversion_output_clock <= bad;
      red_input <= vr;
      green_input <= vg;
      blue_input <= vb;
      video_sample_strobe <= 1'b1;
      repeat (6) @(posedge pclk);
      video_sample_strobe <= 1'b0;
      repeat (6) @(posedge pclk);
      conversion_output_clock <= 1'b0;
   endtask

   task automatic launch();
      @(posedge pclk);
      conversion_output_clock <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask

   task automatic land();
      @(posedge pclk);
      conversion_output_clock <= 1'b0;
      repeat (6) @(posedge pclk);
   endtask

   // clock raised first so the strobe rises inside its high phase
   task automatic set_rs(input logic v);
      @(posedge pclk);
      conversion_output_clock <= 1'b1;
      repeat (2) @(posedge pclk);
      reset_sample_strobe <= v;
   endtask
endmodule

// *** dv/ccd_single_channel_readout_tb.sv ***
// self-checking bench for the single-channel readout
`timescale 1ns/1ps
`define CHK(act, exp) begin check_count++; if ((act) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp); end end
module ccd_single_channel_readout_tb;
   import ccd_readout_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr, byte_bus;
   logic [31:0] pwdata, prdata, rdat;
   logic        clamp_enable_in, serial_config_data, serial_shift_clock;
   logic        register_write_strobe, output_enable_n, rerr;
   logic        conversion_output_clock, reset_sample_strobe, video_sample_strobe;
   logic [15:0] red_input, green_input, blue_input, result_bus, ev;
   logic        result_bus_oe, byte_bus_oe, clamp_active;
   logic [1:0]  codes [3] = '{2'b00, 2'b10, 2'b01};
   logic [15:0] vids [3] = '{16'h1200, 16'h2300, 16'h3400};
   int          miscompares = 0;
   int          check_count = 0;
   wire  [15:0] result_pins = result_bus_oe ? result_bus : 16'hZZZZ;

   ccd_single_channel_readout u_ccd_single_channel_readout (
      .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .conversion_output_clock, .reset_sample_strobe, .video_sample_strobe,
      .clamp_enable_in, .serial_config_data, .serial_shift_clock, .register_write_strobe,
      .output_enable_n, .red_input, .green_input, .blue_input, .result_bus,
      .result_bus_oe, .byte_bus, .byte_bus_oe, .clamp_active
   );

   ccd_timing_model u_ccd_timing_model (
      .pclk, .conversion_output_clock, .reset_sample_strobe, .video_sample_strobe,
      .red_input, .green_input, .blue_input
   );

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         wrap_up();
      end
   endtask

   task automatic ser_write(input logic [2:0] a, input logic [9:0] d);
      logic [12:0] f;
      f = {a, d};
      @(posedge pclk);
      register_write_strobe <= 1'b0;
      for (int i = 12; i >= 0; i--) begin
         repeat (4) @(posedge pclk);
         serial_config_data <= f[i];
         repeat (4) @(posedge pclk);
         serial_shift_clock <= 1'b1;
         repeat (4) @(posedge pclk);
         serial_shift_clock <= 1'b0;
      end
      repeat (4) @(posedge pclk);
      register_write_strobe <= 1'b1;
      repeat (8) @(posedge pclk);
   endtask

   task automatic pixel(input logic [15:0] vr, vg, vb);
      u_ccd_timing_model.sample(16'h0100, vr, vg, vb, 1'b0);
      u_ccd_timing_model.launch();
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      wrap_up();
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {clamp_enable_in, serial_config_data, serial_shift_clock} = '0;
      register_write_strobe = 1'b1;
      output_enable_n = 1'b1;
      presetn = 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (5) @(posedge pclk);
      apb(CONFIG_OFFSET, 1'b0, 32'h0);
      `CHK(rdat, 32'h0)
      `CHK(rerr, 1'b0)
      `CHK(clamp_active, 1'b0)
      `CHK(result_bus_oe, 1'b0)
      clamp_enable_in <= 1'b1;
      u_ccd_timing_model.set_rs(1'b1);
      repeat (6) @(posedge pclk);
      `CHK(clamp_active, 1'b1)
      clamp_enable_in <= 1'b0;
      repeat (6) @(posedge pclk);
      `CHK(clamp_active, 1'b0)
      clamp_enable_in <= 1'b1;
      u_ccd_timing_model.set_rs(1'b0);
      repeat (6) @(posedge pclk);
      `CHK(clamp_active, 1'b0)
      clamp_enable_in <= 1'b0;
      output_enable_n <= 1'b0;
      pixel(16'h1200, 16'h2300, 16'h3400);
      apb(RESULT_OFFSET, 1'b0, 32'h0);
      `CHK(rdat, 32'h0)
      `CHK(result_bus_oe, 1'b1)
      for (int c = 0; c < 3; c++) begin
         apb(CONFIG_OFFSET, 1'b1, {26'h0, codes[c], 4'h8});
         for (int k = 0; k < 2; k++) begin
            pixel(16'h1200 + 16'(k), 16'h2300 + 16'(k), 16'h3400 + 16'(k));
            ev = vids[c] + 16'(k) - 16'h0100;
            `CHK(result_bus, ev)
            `CHK(byte_bus, ev[15:8])
            apb(RESULT_OFFSET, 1'b0, 32'h0);
            `CHK(rdat, {16'h0, ev})
         end
      end
      `CHK(result_pins, 16'h3301)
      apb(OFFSET_B_OFFSET, 1'b1, 32'hFFFFFFFF);
      apb(OFFSET_B_OFFSET, 1'b0, 32'h0);
      `CHK(rdat, 32'h3FF)
      apb(OFFSET_R_OFFSET, 1'b1, 32'h5);
      apb(OFFSET_G_OFFSET, 1'b0, 32'h0);
      `CHK(rdat, 32'h0)
      pixel(16'h1900, 16'h0900, 16'h0900);
      `CHK(result_bus, 16'h07FF)
      pixel(16'h1900, 16'h0900, 16'h0050);
      `CHK(result_bus, 16'h0000)
      apb(STATUS_OFFSET, 1'b1, 32'h1);
      apb(CONFIG_OFFSET, 1'b1, 32'h98);
      pixel(16'h0000, 16'h0000, 16'hA6C4);
      `CHK(byte_bus, 8'hA5)
      `CHK(result_bus, 16'hA500)
      u_ccd_timing_model.land();
      `CHK(byte_bus, 8'hC3)
      apb(STATUS_OFFSET, 1'b0, 32'h0);
      `CHK(rdat[0], 1'b0)
      u_ccd_timing_model.sample(16'h0100, 16'h0, 16'h0, 16'h0200, 1'b1);
      apb(STATUS_OFFSET, 1'b0, 32'h0);
      `CHK(rdat[0], 1'b1)
      apb(STATUS_OFFSET, 1'b1, 32'h1);
      apb(STATUS_OFFSET, 1'b0, 32'h0);
      `CHK(rdat[0], 1'b0)
      output_enable_n <= 1'b1;
      repeat (6) @(posedge pclk);
      `CHK(result_pins, 16'hZZZZ)
      `CHK(byte_bus_oe, 1'b0)
      apb(8'h20, 1'b0, 32'h0);
      `CHK(rerr, 1'b1)
      `CHK(rdat, 32'h0)
      ser_write(SER_CONFIG, 10'h018);
      apb(CONFIG_OFFSET, 1'b0, 32'h0);
      `CHK(rdat, 32'h18)
      ser_write(SER_OFFSET_G, 10'h155);
      apb(OFFSET_G_OFFSET, 1'b0, 32'h0);
      `CHK(rdat, 32'h155)
      wrap_up();
   end
endmodule
